// ===== src/cft_defines.svh
// register offsets, field positions, reset values and counts of the
// clamp flag and temperature channel block
// assumes a 32-bit apb slave with byte addresses in the low 8 bits
`ifndef CFT_DEFINES_SVH
`define CFT_DEFINES_SVH

`define CFT_N_INPUTS       16
`define CFT_ADDR_W         8
`define CFT_OFF_CLAMP_LOW  8'h00
`define CFT_OFF_CLAMP_HIGH 8'h04
`define CFT_OFF_STATUS     8'h08
`define CFT_OFF_REF_CTRL   8'h0c
`define CFT_OFF_TEMP_CTRL  8'h10
`define CFT_OFF_CONFIG     8'h14
`define CFT_OFF_IRQ_STATUS 8'h18
`define CFT_OFF_IRQ_MASK   8'h1c

`define CFT_STATUS_ANY_BIT    0
`define CFT_STATUS_COM_BIT    1
`define CFT_REF_OVSEL_BIT     0
`define CFT_TEMP_EN_BIT       0
`define CFT_CFG_ALERT_THR_BIT 0
`define CFT_CFG_MODE_LSB      1
`define CFT_CFG_HIZ_BIT       3
`define CFT_CFG_UNI_BIT       4
`define CFT_CFG_OSR_LSB       8

`define CFT_REF_CTRL_RST   1'b0
`define CFT_TEMP_CTRL_RST  1'b0
`define CFT_CONFIG_RST     13'h0000
`define CFT_IRQ_W          3
`define CFT_IRQ_CLAMP_BIT  0
`define CFT_IRQ_COM_BIT    1
`define CFT_IRQ_TEMP_BIT   2

`define CFT_CMD_BITS       5
`define CFT_TEMP_CODE      5'h0f
`define CFT_OSR_ONE        4'h0
`define CFT_SIGN_FLIP      16'h8000

`endif

// ===== src/cft_pkg.sv
// types shared by the clamp flag and temperature channel block
// assumes the defines header is compiled alongside
package cft_pkg;

	// sequencing modes of the converter
	typedef enum logic [1:0] {
		CFT_MODE_STD = 2'b00,
		CFT_MODE_ADV = 2'b01,
		CFT_MODE_TWO = 2'b10,
		CFT_MODE_ONE = 2'b11
	} cft_mode_t;

	// temperature insertion machine, one-hot
	typedef enum logic [1:0] {
		CFT_FSM_IDLE = 2'b01,
		CFT_FSM_PEND = 2'b10
	} cft_fsm_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cft_apb_req_t;

	// conversion descriptor handed to the converter core
	typedef struct packed {
		logic       temp;
		logic [3:0] chan;
		logic       hiz;
		logic [3:0] oversampling_ratio;
		logic       unipolar;
		logic       neg_reference_ground;
		logic       thresh_en;
	} cft_conv_t;

endpackage

// ===== src/cft_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent level from outside this clock
`timescale 1ns/1ps
module cft_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// ===== src/cft_top.sv
// clamp flags, overvoltage alert and temperature channel control
// Summary of operation
// (R1) live flag per input clamp, sixteen inputs
// (R2) sticky any-clamp flag, cleared by quiet read
// (R3) live common-input clamp flag, not sticky
// (R4) host reads current clamp states in clamp and status registers
// (R5) alert summary is or of input flags
// (R6) option adds threshold alert to summary
// (R7) current select bit zero enables reduced mode
// (R8) sequencers append temperature after last channel
// (R9) serial code 0x0f selects temperature channel
// (R10) temperature forces high-z and ratio one
// (R11) no threshold alerts for temperature results
// (R12) temperature uses ground negative side, unipolar
// (R13) unipolar results are straight binary codes
// (R14) clamp comparators synchronised before any use
// assumes apb master on clock; clamp, serial pins asynchronous
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "cft_defines.svh"
module cft_top
	import cft_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       reset,
	input  wire cft_apb_req_t               apb_req,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	input  wire logic [`CFT_N_INPUTS-1:0]   clamp_in,
	input  wire logic                       common_clamp_in,
	input  wire logic                       sclk,
	input  wire logic                       sdi,
	input  wire logic                       cs_n,
	input  wire logic                       seq_end,
	input  wire logic                       conv_request,
	input  wire logic [3:0]                 seq_chan,
	input  wire logic                       thresh_alert_in,
	input  wire logic                       result_valid_in,
	input  wire logic [15:0]                result_raw,
	output logic [`CFT_N_INPUTS-1:0]        input_clamp_active,
	output logic                            common_input_clamp_active,
	output logic                            overvoltage_alert_summary,
	output logic                            thresh_alert_out,
	output logic                            ov_reduced_mode,
	output cft_conv_t                       conv,
	output logic                            conv_valid,
	output logic [15:0]                     result_code,
	output logic                            result_valid,
	output logic                            irq
);

	localparam int NSYNC = `CFT_N_INPUTS + 4;

	// whole block state
	typedef struct packed {
		logic                     sclk_d;
		logic [`CFT_CMD_BITS-1:0] shift;
		logic [2:0]               bitcnt;
		logic [3:0]               cmd_chan;
		logic                     cmd_temp;
		logic                     sticky;
		logic                     ovsel;
		logic                     temp_en;
		logic [12:0]              cfg;
		logic [`CFT_IRQ_W-1:0]    irq_st;
		logic [`CFT_IRQ_W-1:0]    irq_mask;
		logic [31:0]              rdata;
		cft_fsm_t                 fsm;
		cft_conv_t                conv;
		logic                     conv_valid;
		logic                     cur_temp;
		logic                     any_d;
		logic                     com_d;
		logic [15:0]              result;
		logic                     result_valid;
		logic                     alert;
		logic                     thr_alert;
	} cft_state_t;

	cft_state_t  st_r;
	cft_state_t  st_nxt;

	logic [NSYNC-1:0]         sync_in;
	logic [NSYNC-1:0]         sync_out;
	logic [`CFT_N_INPUTS-1:0] clamp_s;
	logic                     com_s;
	logic                     sclk_s;
	logic                     sdi_s;
	logic                     cs_n_s;
	logic                     any_clamp;
	logic                     setup_ph;
	logic                     access_ph;
	logic                     wr_en;
	logic                     rd_en;
	logic                     mapped;
	logic [31:0]              rd_mux;
	logic [`CFT_CMD_BITS-1:0] code_full;
	logic                     sclk_rise;
	cft_mode_t                mode;
	cft_conv_t                desc;
	logic                     temp_pick;

	// every pin from outside the clock domain passes two flops
	assign sync_in = {cs_n, sdi, sclk, common_clamp_in, clamp_in}; // R14
	cft_sync #(
		.W        (NSYNC)
	) u_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (sync_in),
		.sync_out (sync_out)
	);
	assign clamp_s = sync_out[`CFT_N_INPUTS-1:0];
	assign com_s   = sync_out[`CFT_N_INPUTS];
	assign sclk_s  = sync_out[`CFT_N_INPUTS+1];
	assign sdi_s   = sync_out[`CFT_N_INPUTS+2];
	assign cs_n_s  = sync_out[`CFT_N_INPUTS+3];

	// live flags straight from the synchronised comparators
	assign input_clamp_active        = clamp_s; // R1
	assign common_input_clamp_active = com_s;   // R3
	assign any_clamp                 = |clamp_s;

	// apb phases; the slave never inserts wait states
	assign setup_ph  = apb_req.psel & ~apb_req.penable;
	assign access_ph = apb_req.psel & apb_req.penable;
	assign wr_en     = access_ph & apb_req.pwrite;
	assign rd_en     = access_ph & ~apb_req.pwrite;
	assign pready    = access_ph;
	assign pslverr   = access_ph & ~mapped;
	assign prdata    = st_r.rdata;

	// configuration fields
	assign mode            = cft_mode_t'(st_r.cfg[`CFT_CFG_MODE_LSB +: 2]);
	assign ov_reduced_mode = ~st_r.ovsel; // R7

	// read decode, clamp states always current
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (apb_req.paddr)
			`CFT_OFF_CLAMP_LOW:  rd_mux = {24'h000000, clamp_s[7:0]};  // R4
			`CFT_OFF_CLAMP_HIGH: rd_mux = {24'h000000, clamp_s[15:8]}; // R4
			`CFT_OFF_STATUS:     rd_mux = {30'h0000_0000, com_s,
			                               st_r.sticky};              // R4
			`CFT_OFF_REF_CTRL:   rd_mux = {31'h0000_0000, st_r.ovsel};
			`CFT_OFF_TEMP_CTRL:  rd_mux = {31'h0000_0000, st_r.temp_en};
			`CFT_OFF_CONFIG:     rd_mux = {19'h00000, st_r.cfg};
			`CFT_OFF_IRQ_STATUS: rd_mux = {29'h0000_0000, st_r.irq_st};
			`CFT_OFF_IRQ_MASK:   rd_mux = {29'h0000_0000, st_r.irq_mask};
			default: begin
				mapped = 1'b0;
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// code as it stands once the fifth bit arrives
	assign code_full = {st_r.shift[`CFT_CMD_BITS-2:0], sdi_s};
	assign sclk_rise = sclk_s & ~st_r.sclk_d;

	// pick the next conversion: pending temperature or command temp
	always_comb begin
		temp_pick = 1'b0;
		if (mode == CFT_MODE_STD || mode == CFT_MODE_ADV) begin
			temp_pick = (st_r.fsm == CFT_FSM_PEND); // R8
		end else begin
			temp_pick = st_r.cmd_temp; // R9
		end
	end

	// build the conversion descriptor
	always_comb begin
		desc            = '0;
		desc.chan       = (mode == CFT_MODE_STD || mode == CFT_MODE_ADV) ?
		                  seq_chan : st_r.cmd_chan;
		desc.hiz        = st_r.cfg[`CFT_CFG_HIZ_BIT];
		desc.oversampling_ratio        = st_r.cfg[`CFT_CFG_OSR_LSB +: 4];
		desc.unipolar   = st_r.cfg[`CFT_CFG_UNI_BIT];
		desc.thresh_en  = 1'b1;
		desc.neg_reference_ground = 1'b0;
		if (temp_pick) begin
			desc.temp       = 1'b1;
			desc.chan       = 4'h0;
			desc.hiz        = 1'b1;         // R10
			desc.oversampling_ratio        = `CFT_OSR_ONE; // R10
			desc.unipolar   = 1'b1;         // R12
			desc.neg_reference_ground = 1'b1;         // R12
			desc.thresh_en  = 1'b0;         // R11
		end
	end

	// next state of the whole block
	always_comb begin
		st_nxt              = st_r;
		st_nxt.conv_valid   = 1'b0;
		st_nxt.result_valid = 1'b0;
		st_nxt.any_d        = any_clamp;
		st_nxt.com_d        = com_s;
		st_nxt.sclk_d       = sclk_s;

		// read data captured in setup so prdata is a flop
		if (setup_ph) begin
			st_nxt.rdata = rd_mux;
		end

		// sticky flag: clamp activity wins over the clearing read
		if (any_clamp) begin
			st_nxt.sticky = 1'b1; // R2
		end else if (rd_en && apb_req.paddr == `CFT_OFF_STATUS) begin
			st_nxt.sticky = 1'b0; // R2
		end

		// register writes
		if (wr_en) begin
			case (apb_req.paddr)
				`CFT_OFF_REF_CTRL:
					st_nxt.ovsel = apb_req.pwdata[`CFT_REF_OVSEL_BIT]; // R7
				`CFT_OFF_TEMP_CTRL:
					st_nxt.temp_en = apb_req.pwdata[`CFT_TEMP_EN_BIT];
				`CFT_OFF_CONFIG:
					st_nxt.cfg = apb_req.pwdata[12:0];
				`CFT_OFF_IRQ_STATUS:
					st_nxt.irq_st = st_r.irq_st &
					                ~apb_req.pwdata[`CFT_IRQ_W-1:0];
				`CFT_OFF_IRQ_MASK:
					st_nxt.irq_mask = apb_req.pwdata[`CFT_IRQ_W-1:0];
				default: begin
					st_nxt.ovsel = st_r.ovsel;
				end
			endcase
		end

		// serial command: five rising edges carry the channel code
		if (cs_n_s) begin
			st_nxt.bitcnt = 3'd0;
			st_nxt.shift  = '0;
		end else if (sclk_rise && st_r.bitcnt < 3'(`CFT_CMD_BITS)) begin
			st_nxt.shift  = code_full;
			st_nxt.bitcnt = st_r.bitcnt + 3'd1;
			if (st_r.bitcnt == 3'(`CFT_CMD_BITS - 1)) begin
				st_nxt.cmd_temp = (code_full == `CFT_TEMP_CODE); // R9
				st_nxt.cmd_chan = code_full[3:0];
			end
		end

		// temperature insertion after the last sequenced channel
		case (st_r.fsm)
			CFT_FSM_IDLE: begin
				if (seq_end && st_r.temp_en &&
				    (mode == CFT_MODE_STD || mode == CFT_MODE_ADV)) begin
					st_nxt.fsm = CFT_FSM_PEND; // R8
				end
			end
			CFT_FSM_PEND: begin
				if (conv_request) begin
					st_nxt.fsm = CFT_FSM_IDLE;
				end
			end
			default: begin
				st_nxt.fsm = CFT_FSM_IDLE;
			end
		endcase

		// issue a descriptor on each core request
		if (conv_request) begin
			st_nxt.conv       = desc;
			st_nxt.conv_valid = 1'b1;
			st_nxt.cur_temp   = desc.temp;
		end

		// result formatting
		if (result_valid_in) begin
			st_nxt.result_valid = 1'b1;
			if (st_r.conv.unipolar) begin
				st_nxt.result = result_raw; // R13
			end else begin
				st_nxt.result = result_raw ^ `CFT_SIGN_FLIP;
			end
		end

		// alert summary and threshold pass-through
		st_nxt.thr_alert = thresh_alert_in & ~st_r.cur_temp; // R11
		st_nxt.alert     = any_clamp; // R5
		if (st_r.cfg[`CFT_CFG_ALERT_THR_BIT]) begin
			st_nxt.alert = any_clamp |
			               (thresh_alert_in & ~st_r.cur_temp); // R6
		end

		// interrupt events set their bits over any clear
		if (any_clamp && !st_r.any_d) begin
			st_nxt.irq_st[`CFT_IRQ_CLAMP_BIT] = 1'b1;
		end
		if (com_s && !st_r.com_d) begin
			st_nxt.irq_st[`CFT_IRQ_COM_BIT] = 1'b1;
		end
		if (conv_request && desc.temp) begin
			st_nxt.irq_st[`CFT_IRQ_TEMP_BIT] = 1'b1;
		end

		// command temp selection holds until the next command; a request clears it only while cs_n stays low after all five bits
		if (conv_request && (mode == CFT_MODE_TWO || mode == CFT_MODE_ONE)) begin
			st_nxt.cmd_temp = st_r.cmd_temp &
			                  ~(st_r.bitcnt == 3'(`CFT_CMD_BITS));
		end
	end

	// register the whole state
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_r          <= '0;
			st_r.ovsel    <= `CFT_REF_CTRL_RST; // R7
			st_r.temp_en  <= `CFT_TEMP_CTRL_RST;
			st_r.cfg      <= `CFT_CONFIG_RST;
			st_r.fsm      <= CFT_FSM_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs from state
	assign conv                      = st_r.conv;
	assign conv_valid                = st_r.conv_valid;
	assign result_code               = st_r.result;
	assign result_valid              = st_r.result_valid;
	assign overvoltage_alert_summary = st_r.alert;
	assign thresh_alert_out          = st_r.thr_alert;
	assign irq                       = |(st_r.irq_st & st_r.irq_mask);

endmodule

// ===== tb/cft_chk_props.sv
// checker for the clamp flag and temperature channel block
// assumes it is bound into cft_top and sees only its ports
`timescale 1ns/1ps
`include "cft_defines.svh"
module cft_chk
	import cft_pkg::*;
(
	input wire logic         clock,
	input wire logic         reset,
	input wire cft_apb_req_t apb_req,
	input wire logic [15:0]  clamp_in,
	input wire logic         common_clamp_in,
	input wire logic         result_valid_in,
	input wire logic [15:0]  result_raw,
	input wire logic [15:0]  input_clamp_active,
	input wire logic         common_input_clamp_active,
	input wire logic         overvoltage_alert_summary,
	input wire logic         thresh_alert_out,
	input wire logic         ov_reduced_mode,
	input wire cft_conv_t    conv,
	input wire logic         result_valid,
	input wire logic [15:0]  result_code
);
	// one clock and reset for all properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// live flags follow quiet pins after the sync depth
	property p_flags;
		$stable(clamp_in)[*3] |-> input_clamp_active == clamp_in;
	endproperty
	a_flags: assert property (p_flags) else $error("input flag");
	property p_com;
		$stable(common_clamp_in)[*3] |->
			common_input_clamp_active == common_clamp_in;
	endproperty
	a_com: assert property (p_com) else $error("common flag");
	// any live input flag raises the summary next cycle
	property p_ovsum;
		|input_clamp_active |=> overvoltage_alert_summary;
	endproperty
	a_ovsum: assert property (p_ovsum) else $error("summary");
	// reduced current mode on after reset, follows the inverted select bit
	property p_ovdef;
		$fell(reset) |-> ov_reduced_mode;
	endproperty
	a_ovdef: assert property (p_ovdef) else $error("mode default");
	property p_ovwr;
		apb_req.psel && apb_req.penable && apb_req.pwrite &&
		apb_req.paddr == `CFT_OFF_REF_CTRL |=>
			ov_reduced_mode == !$past(apb_req.pwdata[0]);
	endproperty
	a_ovwr: assert property (p_ovwr) else $error("mode write");
	// temperature descriptor is forced whatever the config says
	property p_tdesc;
		conv.temp |-> conv.hiz && conv.oversampling_ratio == `CFT_OSR_ONE &&
			conv.unipolar && conv.neg_reference_ground && !conv.thresh_en;
	endproperty
	a_tdesc: assert property (p_tdesc) else $error("temp desc");
	// unipolar results pass straight, others get the sign flip
	property p_res;
		result_valid_in |=> result_valid && result_code ==
			($past(conv.unipolar) ? $past(result_raw) :
			$past(result_raw) ^ `CFT_SIGN_FLIP);
	endproperty
	a_res: assert property (p_res) else $error("result code");
	// no threshold alert while a temperature result is current
	property p_thr;
		conv.temp && $stable(conv.temp) |-> !thresh_alert_out;
	endproperty
	a_thr: assert property (p_thr) else $error("temp alert");
endmodule
bind cft_top cft_chk u_chk (.*);

// ===== tb/cft_host.sv
// host model: shifts one command code into the serial pins
// assumes the bench calls send while no other frame runs
`timescale 1ns/1ps
module cft_host (
	output logic sclk,
	output logic sdi,
	output logic cs_n
);
	// link idles with clock low and select high
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end
	// one frame, msb first, off the system clock edges
	task automatic send(input logic [4:0] code, input int half);
		#1.3;
		cs_n = 1'b0;
		for (int i = 4; i >= 0; i--) begin
			sdi = code[i];
			#(half);
			sclk = 1'b1;
			#(half);
			sclk = 1'b0;
		end
		#(half);
		cs_n = 1'b1;
		sdi = ~sdi; // released line shows no stale value
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the clamp flag and temperature channel block
// assumes design, checker and host model are compiled first
`timescale 1ns/1ps
`include "cft_defines.svh"
module testbench
	import cft_pkg::*;
;
	logic         clock = 1'b0;
	logic         reset = 1'b1;
	cft_apb_req_t apb_req = '0;
	logic [15:0]  clamp_in = 16'h0000;
	logic         common_clamp_in = 1'b0;
	logic         seq_end = 1'b0;
	logic         conv_request = 1'b0;
	logic [3:0]   seq_chan = 4'h3;
	logic         thresh_alert_in = 1'b0;
	logic         result_valid_in = 1'b0;
	logic [15:0]  result_raw = 16'h0000;
	logic         sclk, sdi, cs_n, pready, pslverr, common_input_clamp_active;
	logic         overvoltage_alert_summary, thresh_alert_out, ov_reduced_mode;
	logic         conv_valid, result_valid, irq, err;
	logic [31:0]  prdata, q;
	logic [15:0]  input_clamp_active, result_code;
	cft_conv_t    conv;
	int           miscompares = 0;
	int           n_compared = 0;
	cft_top u_dut (.*);
	cft_host u_host (.sclk(sclk), .sdi(sdi), .cs_n(cs_n));
	// system clock
	always #2 clock = ~clock;
	// compare and report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		apb_req.psel <= 1'b1;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge clock);
		apb_req.penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		q = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// optional sequence end, then one descriptor request
	task automatic cnv(input logic last);
		@(posedge clock);
		seq_end <= last;
		@(posedge clock);
		seq_end <= 1'b0;
		conv_request <= 1'b1;
		@(posedge clock);
		conv_request <= 1'b0;
		#1; // conv_valid stands for this cycle only
	endtask
	task automatic res(input logic [15:0] raw, input logic [15:0] e);
		@(posedge clock);
		result_valid_in <= 1'b1;
		result_raw <= raw;
		@(posedge clock);
		result_valid_in <= 1'b0;
		#1; // result_valid stands for this cycle only
		chk({result_valid, result_code}, {1'b1, e});
	endtask
	// cut a hang short
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		finish_test();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		chk(ov_reduced_mode, 1'b1);
		rd(`CFT_OFF_REF_CTRL, 32'h0);
		wr(`CFT_OFF_REF_CTRL, 32'h1);
		wt(2);
		chk(ov_reduced_mode, 1'b0);
		wr(`CFT_OFF_REF_CTRL, 32'h0);
		rd(8'h20, 32'h0);
		chk(err, 1'b1);
		$display("reset test done");
		clamp_in <= 16'h8001;
		wt(4);
		chk(input_clamp_active, 16'h8001);
		chk(overvoltage_alert_summary, 1'b1);
		rd(`CFT_OFF_CLAMP_LOW, 32'h01);
		rd(`CFT_OFF_CLAMP_HIGH, 32'h80);
		rd(`CFT_OFF_STATUS, 32'h1);
		chk(irq, 1'b0);
		wr(`CFT_OFF_IRQ_MASK, 32'h3);
		wt(2);
		chk(irq, 1'b1);
		@(posedge clock);
		clamp_in <= 16'h0000;
		common_clamp_in <= 1'b1;
		wt(4);
		chk(common_input_clamp_active, 1'b1);
		rd(`CFT_OFF_STATUS, 32'h3);
		rd(`CFT_OFF_STATUS, 32'h2);
		rd(`CFT_OFF_IRQ_STATUS, 32'h3);
		wr(`CFT_OFF_IRQ_STATUS, 32'h3);
		common_clamp_in <= 1'b0;
		wt(4);
		chk(irq, 1'b0);
		rd(`CFT_OFF_STATUS, 32'h0);
		$display("clamp test done");
		thresh_alert_in <= 1'b1;
		wt(4);
		chk(overvoltage_alert_summary, 1'b0);
		chk(thresh_alert_out, 1'b1);
		wr(`CFT_OFF_CONFIG, 32'h1);
		wt(3);
		chk(overvoltage_alert_summary, 1'b1);
		$display("alert test done");
		cnv(1'b1);
		chk({conv_valid, conv.temp, conv.chan}, {2'b10, 4'h3});
		res(16'h1234, 16'h9234);
		wr(`CFT_OFF_TEMP_CTRL, 32'h1);
		cnv(1'b0);
		chk(conv.temp, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(`CFT_OFF_CONFIG, 32'(m) << 1 | 32'hf00);
			if (m > 1) begin
				u_host.send(`CFT_TEMP_CODE, 80);
				wt(8);
			end
			cnv(m < 2);
			chk(conv.temp, 1'b1);
		end
		chk({conv.hiz, conv.oversampling_ratio, conv.unipolar, conv.neg_reference_ground,
			conv.thresh_en}, {1'b1, `CFT_OSR_ONE, 3'b110});
		wt(1);
		chk(thresh_alert_out, 1'b0);
		res(16'h1234, 16'h1234);
		rd(`CFT_OFF_IRQ_STATUS, 32'h4);
		u_host.send(5'h05, 80);
		wt(8);
		cnv(1'b0);
		chk({conv.temp, conv.chan}, {1'b0, 4'h5});
		$display("conversion test done");
		finish_test();
	end
endmodule
